// ### design/cbb_pkg.sv
/*
  Constants shared by the custom bit-field and branch unit: opcode, funct
  fields, field positions, step values and pipeline timing.
  Assumes a 32-bit core with decoded register operands supplied by the pipeline.
*/
// Behaviour
// - branch_ne_imm jumps to pc plus offset when rs1 differs from sign-extended imm
// - mul_by_imm writes rs1 times the sign-extended 9-bit immediate to rd
// - loop_step_branch jumps to pc minus offset when rs1 and rd differ
// - loop_step_branch adds 1, 2, 4 or 8 to rd according to scale
// - set_le_signed writes 1 when rs1 <= rs2 signed, else 0
// - set_le_unsigned writes 1 when rs1 <= rs2 unsigned, else 0
// - field_get_signed_imm extracts the immediate field and sign-extends it
// - field_get_signed_reg takes length and position from rs2 and sign-extends
// - field_get_zero_imm extracts the immediate field and zero-extends it
// - field_get_zero_reg takes length and position from rs2 and zero-extends
// - field_put_imm inserts low rs1 bits into rd, other bits unchanged
// - field_ones_imm ORs a length-plus-one mask at position into rs1
// - field_ones_reg forms the set mask from rs2 and ORs it into rs1
// - field_zeros_imm clears the length-plus-one field at position in rs1
// - field_zeros_reg clears the field given by rs2 in rs1
// - count_leading_same counts bits equal to the msb; zero input gives 0
// - lowest_one_index returns the lowest set bit position, XLEN for zero
// - highest_one_index returns the highest set bit position, XLEN for zero
// - lowest_zero_index counts trailing one bits from the lsb
// - only the illegal instruction exception is ever raised
package cbb_pkg;

  localparam int          XLEN          = 32;
  localparam logic [6:0]  OPC_CUSTOM3   = 7'h7b;

  localparam logic [2:0]  F3_MISC       = 3'h1;
  localparam logic [2:0]  F3_BNEI       = 3'h4;
  localparam logic [2:0]  F3_SLEU       = 3'h3;
  localparam logic [2:0]  F3_EXTRACT    = 3'h5;
  localparam logic [2:0]  F3_SETPUT     = 3'h6;
  localparam logic [2:0]  F3_CLRLOOP    = 3'h7;

  localparam logic [2:0]  TOP3_MULI     = 3'h6;
  localparam logic [6:0]  F7_SLE        = 7'h73;
  localparam logic [6:0]  F7_SLEU       = 7'h74;
  localparam logic [6:0]  F7_CLS        = 7'h75;
  localparam logic [6:0]  F7_LOW1       = 7'h76;
  localparam logic [6:0]  F7_HIGH1      = 7'h77;
  localparam logic [6:0]  F7_LOW0       = 7'h78;

  localparam logic [1:0]  TOP2_00       = 2'h0;
  localparam logic [1:0]  TOP2_01       = 2'h1;
  localparam logic [1:0]  TOP2_10       = 2'h2;
  localparam logic [1:0]  TOP2_11       = 2'h3;

  localparam int          LEN_LSB       = 5;
  localparam int          POS_LSB       = 0;
  localparam logic [31:0] PC_STEP       = 32'h4;
  localparam logic [31:0] RESET_WORD    = 32'h0;
  localparam int          RESULT_LAT    = 1;

  typedef enum logic [4:0] {
    CBB_OP_NONE, CBB_OP_BNEI, CBB_OP_MULI, CBB_OP_LOOP, CBB_OP_SLE, CBB_OP_SLEU,
    CBB_OP_GETS, CBB_OP_GETZ, CBB_OP_PUT, CBB_OP_ONES, CBB_OP_ZEROS,
    CBB_OP_CLS, CBB_OP_LOW1, CBB_OP_HIGH1, CBB_OP_LOW0
  } cbb_op_t;

endpackage

// ### design/cbb_decode.sv
/*
  Instruction decoder for the custom bit-field and branch group.
  Assumes the instruction word is stable while issueValid is high.
*/
`timescale 1ns/1ns
module cbb_decode
  import cbb_pkg::*;
(
  input  wire logic [31:0] instr,
  output cbb_op_t          op,
  output logic             useRegField,
  output logic             illegal
);
  wire [6:0] opcode = instr[6:0];
  wire [2:0] funct3 = instr[14:12];
  wire [6:0] funct7 = instr[31:25];
  wire [1:0] top2   = instr[31:30];
  wire       rs2Zero = (instr[24:20] == 5'h0);
  wire       midZero = (instr[29:25] == 5'h0);

  always_comb begin
    op          = CBB_OP_NONE;
    useRegField = 1'b0;
    if (opcode == OPC_CUSTOM3) begin
      case (funct3)
        F3_BNEI: op = CBB_OP_BNEI;
        F3_MISC: begin
          if (instr[31:29] == TOP3_MULI) op = CBB_OP_MULI;
          else if (funct7 == F7_SLE) op = CBB_OP_SLE;
          else if (funct7 == F7_CLS && rs2Zero) op = CBB_OP_CLS;
          else if (funct7 == F7_LOW1 && rs2Zero) op = CBB_OP_LOW1;
          else if (funct7 == F7_HIGH1 && rs2Zero) op = CBB_OP_HIGH1;
          else if (funct7 == F7_LOW0 && rs2Zero) op = CBB_OP_LOW0;
          else op = CBB_OP_NONE;
        end
        F3_SLEU: op = (funct7 == F7_SLEU) ? CBB_OP_SLEU : CBB_OP_NONE;
        F3_EXTRACT: begin
          case (top2)
            TOP2_00: op = CBB_OP_GETS;
            TOP2_01: begin
              op          = midZero ? CBB_OP_GETS : CBB_OP_NONE;
              useRegField = 1'b1;
            end
            TOP2_10: op = CBB_OP_GETZ;
            default: begin
              op          = midZero ? CBB_OP_GETZ : CBB_OP_NONE;
              useRegField = 1'b1;
            end
          endcase
        end
        F3_SETPUT: begin
          case (top2)
            TOP2_00: op = CBB_OP_PUT;
            TOP2_10: op = CBB_OP_ONES;
            TOP2_11: begin
              op          = midZero ? CBB_OP_ONES : CBB_OP_NONE;
              useRegField = 1'b1;
            end
            default: op = CBB_OP_NONE;
          endcase
        end
        F3_CLRLOOP: begin
          if (instr[31]) op = CBB_OP_LOOP;
          else if (top2 == TOP2_00) op = CBB_OP_ZEROS;
          else begin
            op          = midZero ? CBB_OP_ZEROS : CBB_OP_NONE;
            useRegField = 1'b1;
          end
        end
        default: op = CBB_OP_NONE;
      endcase
    end
  end

  assign illegal = (opcode == OPC_CUSTOM3) && (op == CBB_OP_NONE);
endmodule // cbb_decode

// ### design/cbb_bitscan.sv
/*
  Bit-scan unit: leading-same count, lowest/highest one and lowest zero index.
  Assumes a purely combinational use within one core clock period.
*/
`timescale 1ns/1ns
module cbb_bitscan
  import cbb_pkg::*;
(
  input  wire logic [31:0] value,
  output logic [31:0]      leadSame,
  output logic [31:0]      lowOne,
  output logic [31:0]      highOne,
  output logic [31:0]      lowZero
);
  always_comb begin
    leadSame = RESET_WORD;
    lowOne   = 32'(XLEN);
    highOne  = 32'(XLEN);
    lowZero  = 32'(XLEN);
    for (int i = XLEN - 1; i >= 0; i--) begin
      if (value[i]) lowOne = 32'(i);
      if (!value[i]) lowZero = 32'(i);
    end
    for (int i = 0; i < XLEN; i++) begin
      if (value[i]) highOne = 32'(i);
    end
    if (value != RESET_WORD) begin
      for (int i = XLEN - 1; i >= 0; i--) begin
        if (value[i] == value[XLEN-1] && leadSame == 32'(XLEN - 1 - i))
          leadSame = 32'(XLEN - i);
      end
    end
  end
endmodule // cbb_bitscan

// ### design/cbb_alu.sv
/*
  Execute stage for the custom bit-field and branch group. Results, branch
  redirect, flush and illegal-instruction flag are registered one cycle after issue.
  Assumes the pipeline supplies rs1, rs2, the old rd value and the pc with the
  instruction, and performs its usual flush when flush is raised.
*/
`timescale 1ns/1ns
module cbb_alu
  import cbb_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        issueValid,
  input  wire logic [31:0] instr,
  input  wire logic [31:0] pc,
  input  wire logic [31:0] rs1,
  input  wire logic [31:0] rs2,
  input  wire logic [31:0] rdOld,
  output logic             resultValid,
  output logic [31:0]      result,
  output logic             branchTaken,
  output logic [31:0]      nextPc,
  output logic             flush,
  output logic             illegalInstr
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  cbb_op_t op;
  logic    useRegField;
  logic    decIllegal;

  cbb_decode u_decode (
    .instr       (instr),
    .op          (op),
    .useRegField (useRegField),
    .illegal     (decIllegal)
  );

  // ---------------------------------------------------------------
  // field geometry
  // ---------------------------------------------------------------
  function automatic logic [31:0] ones_below(input logic [5:0] n);
    ones_below = (n >= 6'd32) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
  endfunction

  wire [4:0]  fieldLen  = useRegField ? rs2[LEN_LSB+:5] : instr[29:25];
  wire [4:0]  fieldPos  = useRegField ? rs2[POS_LSB+:5] : instr[24:20];
  wire [5:0]  sumLenPos = {1'b0, fieldLen} + {1'b0, fieldPos};
  // extract top = min(len+pos-1, 31); width = top - pos + 1, empty when len+pos is 0
  wire [5:0]  getTop    = (sumLenPos == 6'd0) ? 6'd0 :
                          ((sumLenPos - 6'd1) > 6'd31 ? 6'd31 : sumLenPos - 6'd1);
  wire [5:0]  getWidth  = ((sumLenPos != 6'd0) && (getTop >= {1'b0, fieldPos})) ?
                          (getTop - {1'b0, fieldPos} + 6'd1) : 6'd0;
  wire [31:0] getRaw    = (rs1 >> fieldPos) & ones_below(getWidth);
  wire        getSign   = (getWidth != 6'd0) && getRaw[getWidth[4:0] - 5'd1];
  wire [31:0] getSext   = getSign ? (getRaw | ~ones_below(getWidth)) : getRaw;

  // set/clear/insert mask: len+1 ones at pos, clipped at bit 31
  wire [31:0] fieldMask = ones_below({1'b0, fieldLen} + 6'd1) << fieldPos;
  wire [31:0] putVal    = (rdOld & ~fieldMask) | ((rs1 << fieldPos) & fieldMask);
  wire [31:0] onesVal   = rs1 | fieldMask;
  wire [31:0] zerosVal  = rs1 & ~fieldMask;

  // ---------------------------------------------------------------
  // arithmetic, compares and scan
  // ---------------------------------------------------------------
  wire [31:0] mulImm    = {{23{instr[28]}}, instr[28:20]};
  wire [63:0] mulFull   = rs1 * mulImm;
  wire [31:0] mulVal    = mulFull[31:0];
  wire [31:0] sleVal    = {31'h0, ($signed(rs1) <= $signed(rs2))};
  wire [31:0] sleuVal   = {31'h0, (rs1 <= rs2)};
  wire [31:0] loopStep  = 32'h1 << instr[30:29];
  wire [31:0] loopVal   = rdOld + loopStep;

  logic [31:0] leadSame;
  logic [31:0] lowOne;
  logic [31:0] highOne;
  logic [31:0] lowZero;

  cbb_bitscan u_scan (
    .value    (rs1),
    .leadSame (leadSame),
    .lowOne   (lowOne),
    .highOne  (highOne),
    .lowZero  (lowZero)
  );

  // ---------------------------------------------------------------
  // branch targets
  // ---------------------------------------------------------------
  wire [31:0] bneOffset = {{19{instr[31]}}, instr[31], instr[7], instr[30:25],
                           instr[11:8], 1'b0};
  wire [31:0] bneImm    = {{27{instr[24]}}, instr[24:20]};
  wire        bneTake   = (rs1 != bneImm);
  wire [31:0] loopOff   = {22'h0, instr[28:20], 1'b0};
  wire        loopTake  = (rs1 != rdOld);

  // ---------------------------------------------------------------
  // result selection
  // ---------------------------------------------------------------
  logic [31:0] next_result;
  logic        next_write;
  logic        next_take;
  logic [31:0] next_pc;

  always_comb begin
    next_result = RESET_WORD;
    next_write  = 1'b1;
    next_take   = 1'b0;
    next_pc     = pc + PC_STEP;
    case (op)
      CBB_OP_BNEI: begin
        next_write = 1'b0;
        next_take  = bneTake;
        next_pc    = bneTake ? pc + bneOffset : pc + PC_STEP;
      end
      CBB_OP_LOOP: begin
        next_result = loopVal;
        next_take   = loopTake;
        next_pc     = loopTake ? pc - loopOff : pc + PC_STEP;
      end
      CBB_OP_MULI:  next_result = mulVal;
      CBB_OP_SLE:   next_result = sleVal;
      CBB_OP_SLEU:  next_result = sleuVal;
      CBB_OP_GETS:  next_result = getSext;
      CBB_OP_GETZ:  next_result = getRaw;
      CBB_OP_PUT:   next_result = putVal;
      CBB_OP_ONES:  next_result = onesVal;
      CBB_OP_ZEROS: next_result = zerosVal;
      CBB_OP_CLS:   next_result = leadSame;
      CBB_OP_LOW1:  next_result = lowOne;
      CBB_OP_HIGH1: next_result = highOne;
      CBB_OP_LOW0:  next_result = lowZero;
      default:      next_write  = 1'b0;
    endcase
  end

  wire issueOk  = issueValid && (op != CBB_OP_NONE);
  wire issueBad = issueValid && decIllegal;

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resultValid  <= 1'b0;
      result       <= RESET_WORD;
      branchTaken  <= 1'b0;
      nextPc       <= RESET_WORD;
      flush        <= 1'b0;
      illegalInstr <= 1'b0;
    end else begin
      resultValid  <= issueOk && next_write;
      result       <= issueOk ? next_result : RESET_WORD;
      branchTaken  <= issueOk && next_take;
      nextPc       <= issueOk ? next_pc : RESET_WORD;
      flush        <= issueOk && next_take;
      illegalInstr <= issueBad;
    end
  end
endmodule // cbb_alu

// ### sim/cbb_alu_assertions.sv
/*
  Checker for the custom bit-field and branch execute unit.
  Assumes it is bound to cbb_alu and sees only that module's ports.
*/
`timescale 1ns/1ns
module cbb_alu_assertions
  import cbb_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        issueValid,
  input wire logic [31:0] instr,
  input wire logic [31:0] pc,
  input wire logic [31:0] rs1,
  input wire logic [31:0] rs2,
  input wire logic [31:0] rdOld,
  input wire logic        resultValid,
  input wire logic [31:0] result,
  input wire logic        branchTaken,
  input wire logic [31:0] nextPc,
  input wire logic        flush,
  input wire logic        illegalInstr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // reference decode and arithmetic
  // ----------------------------------------
  wire logic        isCust     = issueValid && (instr[6:0] == OPC_CUSTOM3);
  wire logic        isBne      = isCust && (instr[14:12] == F3_BNEI);
  wire logic        bneHit     = rs1 != {{27{instr[24]}}, instr[24:20]};
  wire logic [31:0] bneTarget  = pc + {{19{instr[31]}}, instr[31], instr[7], instr[30:25],
                                       instr[11:8], 1'b0};
  wire logic        isLoop     = isCust && instr[31] && (instr[14:12] == F3_CLRLOOP);
  wire logic        loopHit    = rs1 != rdOld;
  wire logic [31:0] loopSum    = rdOld + (32'h1 << instr[30:29]);
  wire logic [31:0] loopTarget = pc - {22'h0, instr[28:20], 1'b0};
  wire logic        isMul      = isCust && (instr[31:29] == TOP3_MULI) &&
                                 (instr[14:12] == F3_MISC);
  wire logic [31:0] mulProd    = rs1 * {{23{instr[28]}}, instr[28:20]};
  wire logic        isSle      = isCust && (instr[31:25] == F7_SLE) && (instr[14:12] == F3_MISC);
  wire logic        sleBit     = $signed(rs1) <= $signed(rs2);

  sequence s_bne_taken;
    isBne && bneHit;
  endsequence
  sequence s_redirect(logic [31:0] target);
    branchTaken && flush && (nextPc == target);
  endsequence

  property p_bne_taken;
    s_bne_taken |=> s_redirect($past(bneTarget));
  endproperty
  a_bne_taken: assert property (p_bne_taken) else $error("bne target wrong");
  property p_bne_fall;
    isBne && !bneHit |=> !branchTaken && (nextPc == $past(pc) + PC_STEP);
  endproperty
  a_bne_fall: assert property (p_bne_fall) else $error("bne fallthrough wrong");
  property p_mul;
    isMul |=> resultValid && (result == $past(mulProd));
  endproperty
  a_mul: assert property (p_mul) else $error("mul product wrong");
  property p_loop_branch;
    isLoop && loopHit |=> s_redirect($past(loopTarget));
  endproperty
  a_loop_branch: assert property (p_loop_branch) else $error("loop target wrong");
  property p_loop_step;
    isLoop |=> resultValid && (result == $past(loopSum));
  endproperty
  a_loop_step: assert property (p_loop_step) else $error("loop step wrong");
  property p_sle;
    isSle |=> resultValid && (result == {31'h0, $past(sleBit)});
  endproperty
  a_sle: assert property (p_sle) else $error("signed compare wrong");
  property p_flush;
    flush == branchTaken;
  endproperty
  a_flush: assert property (p_flush) else $error("flush differs from redirect");
  property p_illegal;
    illegalInstr |-> !resultValid && !branchTaken;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal op has effects");
  property p_foreign;
    !isCust |=> !(resultValid || branchTaken || illegalInstr);
  endproperty
  a_foreign: assert property (p_foreign) else $error("output without own op");
endmodule // cbb_alu_assertions

// ### sim/cbb_pipe_model.sv
/*
  Pipeline partner: fetch pc and register write-back capture.
  Assumes the unit's outputs are registered pulses on core_clk.
*/
`timescale 1ns/1ns
module cbb_pipe_model (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        resultValid,
  input wire logic [31:0] result,
  input wire logic        flush,
  input wire logic [31:0] nextPc,
  output logic [31:0]     fetchPc,
  output logic [31:0]     lastWrite
);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fetchPc   <= 32'h0;
      lastWrite <= 32'h0;
    end else begin
      if (flush) fetchPc <= nextPc;
      if (resultValid) lastWrite <= result;
    end
  end
endmodule // cbb_pipe_model

// ### sim/tb_top.sv
/*
  Self-checking bench for cbb_alu with a pipeline partner model.
  Assumes one issue per cycle, inputs driven 1 ns after the rising edge.
*/
`timescale 1ns/1ns
module tb_top;
  import cbb_pkg::*;
  logic        core_clk, nrst, issueValid;
  logic [31:0] instr, pc, rs1, rs2, rdOld, result, nextPc, fetchPc, lastWrite;
  logic        resultValid, branchTaken, flush, illegalInstr;
  logic [31:0] gotRes, gotPc;
  logic        gotVal, gotBr, gotIll;
  int          bad_count, checks;

  cbb_alu cbb_alu_inst (.core_clk(core_clk), .nrst(nrst), .issueValid(issueValid),
    .instr(instr), .pc(pc), .rs1(rs1), .rs2(rs2), .rdOld(rdOld), .resultValid(resultValid),
    .result(result), .branchTaken(branchTaken), .nextPc(nextPc), .flush(flush),
    .illegalInstr(illegalInstr));
  cbb_pipe_model cbb_pipe_model_inst (.core_clk(core_clk), .nrst(nrst),
    .resultValid(resultValid), .result(result), .flush(flush), .nextPc(nextPc),
    .fetchPc(fetchPc), .lastWrite(lastWrite));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] enc(input logic [6:0] f7, input logic [2:0] f3);
    return {f7, 5'h0, 5'h1, f3, 5'h2, OPC_CUSTOM3};
  endfunction
  function automatic logic [31:0] fld(input logic [1:0] t, input logic [4:0] l, p,
                                      input logic [2:0] f3);
    return {t, l, p, 5'h1, f3, 5'h2, OPC_CUSTOM3};
  endfunction
  task automatic cmp32(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(input logic got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask
  // issue stays high so consecutive calls run back to back
  task automatic exec(input logic [31:0] i, p, a, b, d);
    instr = i; pc = p; rs1 = a; rs2 = b; rdOld = d; issueValid = 1'b1;
    @(posedge core_clk);
    #1;
    gotRes = result; gotPc = nextPc; gotVal = resultValid;
    gotBr = branchTaken; gotIll = illegalInstr;
  endtask
  task automatic idle;
    issueValid = 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic expect_rd(input logic [31:0] i, a, b, d, e);
    exec(i, 32'h200, a, b, d);
    cmpBit(gotVal, 1'b1);
    cmp32(gotRes, e);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_branch;
    exec({7'h0, 5'h1f, 5'h1, F3_BNEI, 5'h10, OPC_CUSTOM3}, 32'h1000, 32'h1, 0, 0);
    cmpBit(gotBr, 1'b1);
    cmp32(gotPc, 32'h1010);
    exec({7'h0, 5'h1f, 5'h1, F3_BNEI, 5'h10, OPC_CUSTOM3}, 32'h1010, 32'hffffffff, 0, 0);
    cmpBit(gotBr, 1'b0);
    cmp32(gotPc, 32'h1014);
    cmp32(fetchPc, 32'h1010);
    idle();
  endtask
  task automatic t_mul_loop;
    expect_rd({3'h6, 9'h1ff, 5'h1, F3_MISC, 5'h2, OPC_CUSTOM3}, 5, 0, 0,
              32'hfffffffb);
    expect_rd({3'h6, 9'h003, 5'h1, F3_MISC, 5'h2, OPC_CUSTOM3}, 7, 0, 0,
              32'h15);
    for (int s = 0; s < 4; s++) begin
      exec({1'b1, 2'(s), 9'h003, 5'h1, F3_CLRLOOP, 5'h2, OPC_CUSTOM3}, 32'h100,
           (s == 3) ? 32'ha : 32'h0, 0, 32'ha);
      cmp32(gotRes, 32'ha + (32'h1 << s));
      cmpBit(gotBr, s != 3);
      cmp32(gotPc, (s == 3) ? 32'h104 : 32'hfa);
    end
    idle();
  endtask
  task automatic t_compare;
    expect_rd(enc(F7_SLE, F3_MISC), 32'hffffffff, 32'h1, 0, 32'h1);
    expect_rd(enc(F7_SLE, F3_MISC), 32'h1, 32'hffffffff, 0, 32'h0);
    expect_rd(enc(F7_SLE, F3_MISC), 32'h5, 32'h5, 0, 32'h1);
    expect_rd(enc(F7_SLEU, F3_SLEU), 32'hffffffff, 32'h1, 0, 32'h0);
    expect_rd(enc(F7_SLEU, F3_SLEU), 32'h1, 32'hffffffff, 0, 32'h1);
    idle();
  endtask
  task automatic t_fields;
    expect_rd(fld(0, 4, 4, F3_EXTRACT), 32'hf0, 0, 0, 32'hffffffff);
    expect_rd(fld(0, 8, 28, F3_EXTRACT), 32'h70000000, 0, 0, 32'h7);
    expect_rd(fld(1, 0, 0, F3_EXTRACT), 32'hf0, 32'h84, 0, 32'hffffffff);
    expect_rd(fld(2, 4, 4, F3_EXTRACT), 32'hf0, 0, 0, 32'hf);
    expect_rd(fld(2, 0, 0, F3_EXTRACT), 32'hffffffff, 0, 0, 32'h0);
    expect_rd(fld(3, 0, 0, F3_EXTRACT), 32'hf0, 32'h84, 0, 32'hf);
    expect_rd(fld(0, 3, 8, F3_SETPUT), 32'h5, 0, 32'hffffffff, 32'hfffff5ff);
    expect_rd(fld(2, 3, 4, F3_SETPUT), 32'h0, 0, 0, 32'hf0);
    expect_rd(fld(3, 0, 0, F3_SETPUT), 32'h0, 32'h64, 0, 32'hf0);
    expect_rd(fld(0, 3, 4, F3_CLRLOOP), 32'hffffffff, 0, 0, 32'hffffff0f);
    expect_rd(fld(1, 0, 0, F3_CLRLOOP), 32'hffffffff, 32'h64, 0, 32'hffffff0f);
    idle();
    cmp32(lastWrite, 32'hffffff0f);
  endtask
  task automatic t_scan;
    expect_rd(enc(F7_CLS, F3_MISC), 32'h0, 0, 0, 32'd0);
    expect_rd(enc(F7_CLS, F3_MISC), 32'hf0000000, 0, 0, 32'd4);
    expect_rd(enc(F7_CLS, F3_MISC), 32'h0000ffff, 0, 0, 32'd16);
    expect_rd(enc(F7_LOW1, F3_MISC), 32'h80001000, 0, 0, 32'd12);
    expect_rd(enc(F7_LOW1, F3_MISC), 32'h0, 0, 0, 32'd32);
    expect_rd(enc(F7_HIGH1, F3_MISC), 32'h80001000, 0, 0, 32'd31);
    expect_rd(enc(F7_HIGH1, F3_MISC), 32'h0, 0, 0, 32'd32);
    expect_rd(enc(F7_LOW0, F3_MISC), 32'h80001000, 0, 0, 32'd0);
    expect_rd(enc(F7_LOW0, F3_MISC), 32'hf, 0, 0, 32'd4);
    expect_rd(enc(F7_LOW0, F3_MISC), 32'hffffffff, 0, 0, 32'd32);
    idle();
  endtask
  task automatic t_illegal;
    exec(enc(7'h7f, F3_MISC), 32'h300, 32'h1, 0, 0);
    cmpBit(gotIll, 1'b1);
    cmpBit(gotVal, 1'b0);
    exec(fld(1, 1, 0, F3_EXTRACT), 32'h304, 32'h1, 0, 0);
    cmpBit(gotIll, 1'b1);
    exec({25'h0, 7'h33}, 32'h308, 32'h1, 0, 0);
    cmpBit(gotIll | gotVal | gotBr, 1'b0);
    idle();
  endtask

  task automatic summarize;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  initial begin
    nrst = 1'b0; issueValid = 1'b0; instr = 0; pc = 0; rs1 = 0; rs2 = 0; rdOld = 0;
    bad_count = 0; checks = 0;
    repeat (12) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    @(posedge core_clk);
    #1;
    cmp32(result, 32'h0);
    t_branch();
    t_mul_loop();
    t_compare();
    t_fields();
    t_scan();
    t_illegal();
    summarize();
  end
endmodule // tb_top

bind cbb_alu cbb_alu_assertions cbb_alu_assertions_inst (.core_clk(core_clk), .nrst(nrst),
  .issueValid(issueValid), .instr(instr), .pc(pc), .rs1(rs1), .rs2(rs2), .rdOld(rdOld),
  .resultValid(resultValid), .result(result), .branchTaken(branchTaken), .nextPc(nextPc),
  .flush(flush), .illegalInstr(illegalInstr));
